// *** bse_compare.sv ***
// Compare unit: subtracts an immediate from a register and forms the flags.
// Assumes purely combinational use inside the execution unit; result is discarded.
`timescale 1ns/100ps
module bse_compare
  import bse_pkg::*;
(
  // Operands.
  input wire logic [DATA_W-1:0] regValue,
  input wire logic [DATA_W-1:0] immValue,
  // Flags in and out.
  input wire logic [DATA_W-1:0] flagsIn,
  output logic [DATA_W-1:0] flagsOut
);

  logic [DATA_W-1:0] diff;

  // ****************************************************************
  // Subtraction and flag forming.
  // ****************************************************************

  // Difference is only used for flags and never written back.
  assign diff = regValue - immValue;

  // Zero, negative, overflow, carry and half-carry follow the difference.
  always_comb begin
    flagsOut = flagsIn;
    flagsOut[FLAG_Z] = (diff == DATA_RESET);
    flagsOut[FLAG_N] = diff[7];
    flagsOut[FLAG_V] = (regValue[7] & ~immValue[7] & ~diff[7]) |
                       (~regValue[7] & immValue[7] & diff[7]);
    flagsOut[FLAG_C] = (~regValue[7] & immValue[7]) | (immValue[7] & diff[7]) |
                       (diff[7] & ~regValue[7]);
    flagsOut[FLAG_H] = (~regValue[3] & immValue[3]) | (immValue[3] & diff[3]) |
                       (diff[3] & ~regValue[3]);
  end

endmodule

// *** bse_exec.sv ***
// Execution unit for compare-immediate, bit skips, flag branches, stack and core control.
// Assumes the core presents one operation at a time with operands valid in the issue cycle,
// and that the stack returns pop data while the pop strobe stands.
//
// Summary of operation
// - Compare immediate sets five flags, one cycle.
// - Register bit clear skips; PC plus 2/3.
// - I/O bit set skips; flags untouched.
// - Flag-set branch: PC+k+1, one/two cycles.
// - Flag-clear branch: same target and timing.
// - Equal/not-equal branches test zero flag.
// - Carry branches; same-higher/lower alias them.
// - Same-or-higher taken exactly when carry clear.
// - Signed greater-equal taken when N xor V clear.
// - Signed less-than taken when N xor V set.
// - Half-carry branches test half-carry flag.
// - Push writes stack, two cycles, flags kept.
// - Pop loads register, two cycles, flags kept.
// - Sleep issues in one cycle, requests sleep.
// - Watchdog restart: one cycle, signals the watchdog.
// - Break serves debug only, no fixed count.
`timescale 1ns/100ps
module bse_exec
  import bse_pkg::*;
#(
  parameter int PC_W = PC_W_DEF,
  parameter int OFFSET_W = OFFSET_W_DEF
)(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Issue of one operation.
  input wire logic opValid,
  input wire bse_op_e opCode,
  input wire logic [DATA_W-1:0] regValue,
  input wire logic [DATA_W-1:0] immValue,
  input wire logic [DATA_W-1:0] ioValue,
  input wire logic [2:0] bitSel,
  input wire logic [OFFSET_W-1:0] offset,
  input wire logic nextIsLong,
  // Program counter and status flags.
  input wire logic [PC_W-1:0] pcCurrent,
  input wire logic [DATA_W-1:0] statusFlags,
  // Stack read data and debug resume.
  input wire logic [DATA_W-1:0] stackData,
  input wire logic debugResume,
  // Completion and program counter update.
  output logic busy,
  output logic done,
  output logic pcLoad,
  output logic [PC_W-1:0] pcNext,
  // Status flag update.
  output logic flagsWrite,
  output logic [DATA_W-1:0] flagsNew,
  // Stack and register file.
  output logic stackPush,
  output logic stackPop,
  output logic [DATA_W-1:0] stackWrData,
  output logic regWrite,
  output logic [DATA_W-1:0] regWrData,
  // Core control strobes.
  output logic sleepReq,
  output logic wdtRestart,
  output logic debugBreak
);

  // ****************************************************************
  // Condition decoding.
  // ****************************************************************

  // Returns whether a conditional branch is taken for the given flags.
  function automatic logic branchTaken(input bse_op_e op, input logic [DATA_W-1:0] f,
                                       input logic [2:0] sel);
    logic taken;
    taken = 1'b0;
    unique case (op)
      branch_flag_set_op: taken = f[sel];
      branch_flag_clear_op: taken = ~f[sel];
      branch_equal_op: taken = f[FLAG_Z];
      branch_not_equal_op: taken = ~f[FLAG_Z];
      branch_carry_set_op, branch_lower_op: taken = f[FLAG_C];
      branch_carry_clear_op: taken = ~f[FLAG_C];
      branch_same_higher_op: taken = ~f[FLAG_C];
      branch_signed_ge_op: taken = ~(f[FLAG_N] ^ f[FLAG_V]);
      branch_signed_lt_op: taken = f[FLAG_N] ^ f[FLAG_V];
      branch_halfcarry_set_op: taken = f[FLAG_H];
      branch_halfcarry_clear_op: taken = ~f[FLAG_H];
      default: taken = 1'b0;
    endcase
    return taken;
  endfunction

  // Returns whether the operation is one of the conditional branches.
  function automatic logic isBranch(input bse_op_e op);
    return (op >= branch_flag_set_op) && (op <= branch_halfcarry_clear_op);
  endfunction

  // ****************************************************************
  // Operand preparation.
  // ****************************************************************

  logic [DATA_W-1:0] cmpFlags;
  logic [PC_W-1:0] pcPlusOne;
  logic [PC_W-1:0] offsetExt;
  logic skipCond;

  // Flag forming for compare with immediate.
  bse_compare u_compare (
    .regValue(regValue),
    .immValue(immValue),
    .flagsIn(statusFlags),
    .flagsOut(cmpFlags)
  );

  // Incremented counter and sign-extended word offset.
  assign pcPlusOne = pcCurrent + PC_W'(1);
  assign offsetExt = PC_W'($signed(offset));

  // Skip condition for the four bit-test instructions.
  always_comb begin
    unique case (opCode)
      skip_reg_bit_clear_op: skipCond = ~regValue[bitSel];
      skip_reg_bit_set_op: skipCond = regValue[bitSel];
      skip_io_bit_clear_op: skipCond = ~ioValue[bitSel];
      skip_io_bit_set_op: skipCond = ioValue[bitSel];
      default: skipCond = 1'b0;
    endcase
  end

  // ****************************************************************
  // Sequencer.
  // ****************************************************************

  bse_state_e state;
  bse_state_e next_state;
  logic [1:0] remain;
  logic [1:0] next_remain;
  logic next_busy;
  logic next_done;
  logic next_pcLoad;
  logic [PC_W-1:0] next_pcNext;
  logic next_flagsWrite;
  logic [DATA_W-1:0] next_flagsNew;
  logic next_stackPush;
  logic next_stackPop;
  logic [DATA_W-1:0] next_stackWrData;
  logic next_regWrite;
  logic [DATA_W-1:0] next_regWrData;
  logic next_sleepReq;
  logic next_wdtRestart;
  logic next_debugBreak;
  logic isPop;
  logic next_isPop;
  logic [1:0] cycles;

  // Computes the result of an issued operation and walks its cycle count.
  always_comb begin
    next_state = state;
    next_remain = remain;
    next_busy = busy;
    next_done = 1'b0;
    next_pcLoad = 1'b0;
    next_pcNext = pcNext;
    next_flagsWrite = 1'b0;
    next_flagsNew = flagsNew;
    next_stackPush = 1'b0;
    next_stackPop = 1'b0;
    next_stackWrData = stackWrData;
    next_regWrite = 1'b0;
    next_regWrData = regWrData;
    next_sleepReq = 1'b0;
    next_wdtRestart = 1'b0;
    next_debugBreak = 1'b0;
    next_isPop = isPop;
    cycles = CYC_ONE;
    unique case (state)
      ST_IDLE: begin
        if (opValid) begin
          next_pcNext = pcPlusOne;
          next_isPop = 1'b0;
          if (opCode == compare_immediate_op) begin
            next_flagsWrite = 1'b1;
            next_flagsNew = cmpFlags;
          end else if (opCode <= skip_io_bit_set_op) begin
            if (skipCond) begin
              // A skipped long instruction costs one more word and cycle.
              next_pcNext = nextIsLong ? pcCurrent + PC_W'(3) : pcCurrent + PC_W'(2);
              cycles = nextIsLong ? CYC_THREE : CYC_TWO;
            end
          end else if (isBranch(opCode)) begin
            if (branchTaken(opCode, statusFlags, bitSel)) begin
              next_pcNext = pcPlusOne + offsetExt;
              cycles = CYC_TWO;
            end
          end else if (opCode == push_op) begin
            next_stackPush = 1'b1;
            next_stackWrData = regValue;
            cycles = CYC_TWO;
          end else if (opCode == pop_op) begin
            next_stackPop = 1'b1;
            next_isPop = 1'b1;
            cycles = CYC_TWO;
          end else if (opCode == sleep_op) begin
            next_sleepReq = 1'b1;
          end else if (opCode == watchdog_restart_op) begin
            next_wdtRestart = 1'b1;
          end else if (opCode == break_op) begin
            // The debug system holds the core until it resumes it.
            next_debugBreak = 1'b1;
            next_busy = 1'b1;
            next_state = ST_BREAK;
          end
          // Single-cycle operations finish now; longer ones count down in the wait state.
          if (opCode != break_op) begin
            if (cycles == CYC_ONE) begin
              next_done = 1'b1;
              next_pcLoad = 1'b1;
            end else begin
              next_busy = 1'b1;
              next_remain = cycles - CYC_ONE;
              next_state = ST_WAIT;
            end
          end
        end
      end
      ST_WAIT: begin
        // Issue requests are ignored here, so the core must wait for done.
        if (remain == CYC_ONE) begin
          next_done = 1'b1;
          next_pcLoad = 1'b1;
          next_busy = 1'b0;
          next_state = ST_IDLE;
          // Pop data is taken in the cycle in which the pop strobe stands.
          if (isPop) begin
            next_regWrite = 1'b1;
            next_regWrData = stackData;
          end
        end else begin
          next_remain = remain - CYC_ONE;
        end
      end
      ST_BREAK: begin
        // The debug system may hold the core here for any number of cycles.
        if (debugResume) begin
          next_done = 1'b1;
          next_pcLoad = 1'b1;
          next_busy = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: begin
        // An illegal state code returns to idle without completing anything.
        next_state = ST_IDLE;
        next_busy = 1'b0;
      end
    endcase
  end

  // Registers the sequencer and every output.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state <= ST_IDLE;
      remain <= 2'h0;
      isPop <= 1'b0;
      busy <= 1'b0;
      done <= 1'b0;
      pcLoad <= 1'b0;
      pcNext <= '0;
      flagsWrite <= 1'b0;
      flagsNew <= DATA_RESET;
      stackPush <= 1'b0;
      stackPop <= 1'b0;
      stackWrData <= DATA_RESET;
      regWrite <= 1'b0;
      regWrData <= DATA_RESET;
      sleepReq <= 1'b0;
      wdtRestart <= 1'b0;
      debugBreak <= 1'b0;
    end else begin
      state <= next_state;
      remain <= next_remain;
      isPop <= next_isPop;
      busy <= next_busy;
      done <= next_done;
      pcLoad <= next_pcLoad;
      pcNext <= next_pcNext;
      flagsWrite <= next_flagsWrite;
      flagsNew <= next_flagsNew;
      stackPush <= next_stackPush;
      stackPop <= next_stackPop;
      stackWrData <= next_stackWrData;
      regWrite <= next_regWrite;
      regWrData <= next_regWrData;
      sleepReq <= next_sleepReq;
      wdtRestart <= next_wdtRestart;
      debugBreak <= next_debugBreak;
    end
  end

endmodule

// *** bse_exec_monitor.sv ***
// Checker for the execution unit, watching only its top-level ports.
// Assumes the one core clock and the active-high asynchronous reset.
`timescale 1ns/100ps
module bse_exec_monitor
  import bse_pkg::*;
#(
  parameter int PC_W = PC_W_DEF
)(
  // Clock and reset.
  input wire logic core_clk,
  input wire logic rst,
  // Issue side.
  input wire logic opValid,
  input wire bse_op_e opCode,
  input wire logic [DATA_W-1:0] regValue,
  input wire logic [DATA_W-1:0] immValue,
  input wire logic [PC_W-1:0] pcCurrent,
  input wire logic [DATA_W-1:0] statusFlags,
  input wire logic [DATA_W-1:0] stackData,
  // Results.
  input wire logic busy,
  input wire logic done,
  input wire logic pcLoad,
  input wire logic [PC_W-1:0] pcNext,
  input wire logic flagsWrite,
  input wire logic [DATA_W-1:0] flagsNew,
  input wire logic stackPush,
  input wire logic stackPop,
  input wire logic [DATA_W-1:0] stackWrData,
  input wire logic regWrite,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic sleepReq,
  input wire logic wdtRestart,
  input wire logic debugBreak
);
  // ********************************
  // Issue qualifier and properties.
  // ********************************
  // An operation is only taken while the unit is idle.
  wire issue = opValid && !busy;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  cmp_one_cycle_a: assert property (issue && opCode == compare_immediate_op |=>
    done && flagsWrite && pcNext == $past(pcCurrent) + 1) else $error("compare timing wrong");
  cmp_flag_value_a: assert property (issue && opCode == compare_immediate_op |=>
    flagsNew[FLAG_Z] == ($past(regValue) == $past(immValue))
    && flagsNew[FLAG_C] == ($past(regValue) < $past(immValue))) else $error("compare flags wrong");
  skip_no_flags_a: assert property (issue && opCode >= skip_reg_bit_clear_op
    && opCode <= skip_io_bit_set_op |=> !flagsWrite && !stackPush && !regWrite)
    else $error("skip touched flags");
  push_two_cycle_a: assert property (issue && opCode == push_op |=>
    stackPush && stackWrData == $past(regValue) && !done ##1 done && !flagsWrite)
    else $error("push sequence wrong");
  pop_two_cycle_a: assert property (issue && opCode == pop_op |=>
    stackPop && !done ##1 done && regWrite && regWrData == $past(stackData))
    else $error("pop sequence wrong");
  sleep_one_cycle_a: assert property (issue && opCode == sleep_op |=>
    sleepReq && done && !flagsWrite) else $error("sleep issue wrong");
  wdt_one_cycle_a: assert property (issue && opCode == watchdog_restart_op |=>
    wdtRestart && done && !flagsWrite) else $error("watchdog restart wrong");
  break_holds_a: assert property (issue && opCode == break_op |=>
    debugBreak && busy && !done) else $error("break did not hold");
  eq_taken_a: assert property (issue && opCode == branch_equal_op
    && statusFlags[FLAG_Z] |=> busy && !done ##1 done)
    else $error("taken equal branch timing wrong");
  ne_untaken_a: assert property (issue && opCode == branch_not_equal_op
    && statusFlags[FLAG_Z] |=> done && pcNext == $past(pcCurrent) + 1)
    else $error("untaken branch wrong");
  load_with_done_a: assert property (pcLoad == done)
    else $error("pc load apart from done");
endmodule

bind bse_exec bse_exec_monitor #(.PC_W(PC_W)) mon (
  .core_clk(core_clk), .rst(rst), .opValid(opValid), .opCode(opCode),
  .regValue(regValue), .immValue(immValue), .pcCurrent(pcCurrent),
  .statusFlags(statusFlags), .stackData(stackData), .busy(busy), .done(done),
  .pcLoad(pcLoad), .pcNext(pcNext), .flagsWrite(flagsWrite), .flagsNew(flagsNew),
  .stackPush(stackPush), .stackPop(stackPop), .stackWrData(stackWrData),
  .regWrite(regWrite), .regWrData(regWrData), .sleepReq(sleepReq),
  .wdtRestart(wdtRestart), .debugBreak(debugBreak)
);

// *** bse_exec_tb.sv ***
// Self-checking bench for the execution unit, driving every input at the falling edge.
// Assumes the default widths: 16-bit program counter and 7-bit branch offset.
`timescale 1ns/100ps
module bse_exec_tb;
  import bse_pkg::*;
  // ********************************
  // Stimulus, results and counters.
  // ********************************
  logic core_clk = 1'b0, rst = 1'b1, opValid = 1'b0, nextIsLong = 1'b0, debugResume = 1'b0;
  bse_op_e opCode = compare_immediate_op;
  logic [7:0] regValue = 8'h00, immValue = 8'h00, ioValue = 8'h00;
  logic [7:0] statusFlags = 8'h00, stackData = 8'h00;
  logic [2:0] bitSel = 3'h0;
  logic [6:0] offset = 7'h00;
  logic [15:0] pcCurrent = 16'h0000, pcNext;
  logic busy, done, pcLoad, flagsWrite, stackPush, stackPop, regWrite;
  logic sleepReq, wdtRestart, debugBreak;
  logic [7:0] flagsNew, stackWrData, regWrData;
  logic [5:0] s1;
  int numErrors = 0, checks = 0, cycles = 0, n;

  bse_exec dut (
    .core_clk(core_clk), .rst(rst), .opValid(opValid), .opCode(opCode),
    .regValue(regValue), .immValue(immValue), .ioValue(ioValue), .bitSel(bitSel),
    .offset(offset), .nextIsLong(nextIsLong), .pcCurrent(pcCurrent),
    .statusFlags(statusFlags), .stackData(stackData), .debugResume(debugResume),
    .busy(busy), .done(done), .pcLoad(pcLoad), .pcNext(pcNext), .flagsWrite(flagsWrite),
    .flagsNew(flagsNew), .stackPush(stackPush), .stackPop(stackPop),
    .stackWrData(stackWrData), .regWrite(regWrite), .regWrData(regWrData),
    .sleepReq(sleepReq), .wdtRestart(wdtRestart), .debugBreak(debugBreak)
  );

  // Clock of 100 ns and a cycle ceiling that cuts a hang short.
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 2000) begin
      numErrors++;
      test_done();
    end
  end

  // Compares one result, counting it and reporting a mismatch.
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      numErrors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // Issues one operation, records the first-cycle strobes and counts cycles to done.
  task automatic run_op(input bse_op_e o, input logic [15:0] pc);
    @(negedge core_clk);
    opCode = o;
    pcCurrent = pc;
    opValid = 1'b1;
    @(negedge core_clk);
    opValid = 1'b0;
    s1 = {flagsWrite, stackPush, stackPop, sleepReq, wdtRestart, debugBreak};
    n = 1;
    while (done !== 1'b1 && n < 8) begin
      @(negedge core_clk);
      n++;
    end
  endtask

  // Expected branch decision from the flags; generic branches look at bit 2.
  function automatic logic taken(input bse_op_e o, input logic [7:0] f);
    case (o)
      branch_flag_set_op: return f[2];
      branch_flag_clear_op: return !f[2];
      branch_equal_op: return f[FLAG_Z];
      branch_not_equal_op: return !f[FLAG_Z];
      branch_carry_set_op, branch_lower_op: return f[FLAG_C];
      branch_carry_clear_op, branch_same_higher_op: return !f[FLAG_C];
      branch_signed_ge_op: return !(f[FLAG_N] ^ f[FLAG_V]);
      branch_signed_lt_op: return f[FLAG_N] ^ f[FLAG_V];
      branch_halfcarry_set_op: return f[FLAG_H];
      default: return !f[FLAG_H];
    endcase
  endfunction

  // ********************************
  // Scenarios.
  // ********************************
  // Every branch under four flag patterns, with forward and backward offsets.
  task automatic t_branches();
    logic [7:0] fl [4] = '{8'h00, 8'hff, 8'h0a, 8'h24};
    logic t;
    bitSel = 3'h2;
    for (int o = int'(branch_flag_set_op); o <= int'(branch_halfcarry_clear_op); o++) begin
      for (int i = 0; i < 4; i++) begin
        statusFlags = fl[i];
        offset = i[0] ? 7'h7e : 7'h05;
        t = taken(bse_op_e'(o), fl[i]);
        run_op(bse_op_e'(o), 16'h0100);
        chk(pcNext, t ? 16'h0101 + {{9{offset[6]}}, offset} : 16'h0101);
        chk(16'(n), t ? 16'h0002 : 16'h0001);
      end
    end
  endtask

  // All four skips over short and long followers; clear variants have odd codes.
  task automatic t_skips();
    logic sk;
    bitSel = 3'h4;
    for (int o = int'(skip_reg_bit_clear_op); o <= int'(skip_io_bit_set_op); o++) begin
      for (int v = 0; v < 4; v++) begin
        regValue = v[0] ? 8'h10 : 8'hef;
        ioValue = regValue;
        nextIsLong = v[1];
        sk = o[0] ? !v[0] : v[0];
        run_op(bse_op_e'(o), 16'h0200);
        chk(pcNext, sk ? 16'h0202 + v[1] : 16'h0201);
        chk(16'(n), sk ? 16'h0002 + v[1] : 16'h0001);
        chk(16'(s1), 16'h0000);
      end
    end
  endtask

  // Compare with equal, borrowing and overflowing operands; S, T and I are kept.
  task automatic t_compare();
    logic [7:0] r [3] = '{8'h05, 8'h03, 8'h80};
    logic [7:0] k [3] = '{8'h05, 8'h05, 8'h01};
    logic [7:0] d, e;
    statusFlags = 8'hd0;
    for (int i = 0; i < 3; i++) begin
      regValue = r[i];
      immValue = k[i];
      d = r[i] - k[i];
      e = {2'h3, r[i][3:0] < k[i][3:0], 1'b1, 4'h0};
      e[FLAG_V] = r[i][7] & ~k[i][7] & ~d[7] | ~r[i][7] & k[i][7] & d[7];
      e[FLAG_N] = d[7];
      e[FLAG_Z] = d == 8'h00;
      e[FLAG_C] = r[i] < k[i];
      run_op(compare_immediate_op, 16'h0300);
      chk(16'(flagsNew), 16'(e));
      chk(16'({s1, n[1:0]}), 16'h0081);
    end
  endtask

  // Push then pop back to back, followed by sleep and watchdog restart.
  task automatic t_stack_ctrl();
    regValue = 8'h5a;
    stackData = 8'ha5;
    run_op(push_op, 16'h0400);
    chk(16'({s1, stackWrData, n[1:0]}), 16'h416a);
    run_op(pop_op, 16'h0401);
    chk(16'({s1, regWrData, n[1:0]}), 16'h2296);
    chk(pcNext, 16'h0402);
    run_op(sleep_op, 16'h0410);
    chk(16'({s1, n[1:0]}), 16'h0011);
    run_op(watchdog_restart_op, 16'h0420);
    chk(16'({s1, n[1:0]}), 16'h0009);
    chk(pcNext, 16'h0421);
  endtask

  // Break waits for resume and refuses a compare issued meanwhile.
  task automatic t_break();
    @(negedge core_clk);
    opCode = break_op;
    pcCurrent = 16'h0500;
    opValid = 1'b1;
    @(negedge core_clk);
    opCode = compare_immediate_op;
    chk(16'({debugBreak, busy}), 16'h0003);
    @(negedge core_clk);
    opValid = 1'b0;
    // A compare taken by mistake would show its one-cycle flag strobe right here.
    chk(16'({flagsWrite, done, busy}), 16'h0001);
    repeat (3) @(negedge core_clk);
    chk(16'({flagsWrite, done, busy}), 16'h0001);
    debugResume = 1'b1;
    @(negedge core_clk);
    debugResume = 1'b0;
    chk(16'({done, busy}), 16'h0002);
    chk(pcNext, 16'h0501);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic test_done();
    $display("errors %0d checks %0d", numErrors, checks);
    if (numErrors == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Main sequence: five cycles of reset, then each scenario in turn.
  initial begin
    repeat (5) @(negedge core_clk);
    rst = 1'b0;
    chk(16'({busy, done, pcLoad, flagsWrite}), 16'h0000);
    t_compare();
    t_skips();
    t_branches();
    t_stack_ctrl();
    t_break();
    test_done();
  end
endmodule

// *** bse_pkg.sv ***
// Package for the branch, skip, stack and core-control execution unit.
// Assumes a single core clock domain; shared by the execution unit and its compare unit.
package bse_pkg;

  // ****************************************************************
  // Status flag bit positions.
  // ****************************************************************
  localparam int FLAG_C = 0;
  localparam int FLAG_Z = 1;
  localparam int FLAG_N = 2;
  localparam int FLAG_V = 3;
  localparam int FLAG_S = 4;
  localparam int FLAG_H = 5;
  localparam int FLAG_T = 6;
  localparam int FLAG_I = 7;

  // ****************************************************************
  // Widths, reset values and cycle counts.
  // ****************************************************************
  localparam int DATA_W = 8;
  localparam int PC_W_DEF = 16;
  localparam int OFFSET_W_DEF = 7;
  localparam logic [1:0] CYC_ONE = 2'h1;
  localparam logic [1:0] CYC_TWO = 2'h2;
  localparam logic [1:0] CYC_THREE = 2'h3;
  localparam logic [7:0] DATA_RESET = 8'h00;

  // ****************************************************************
  // Operations handled by this unit.
  // ****************************************************************
  typedef enum logic [4:0] {
    compare_immediate_op = 5'h00,
    skip_reg_bit_clear_op = 5'h01,
    skip_reg_bit_set_op = 5'h02,
    skip_io_bit_clear_op = 5'h03,
    skip_io_bit_set_op = 5'h04,
    branch_flag_set_op = 5'h05,
    branch_flag_clear_op = 5'h06,
    branch_equal_op = 5'h07,
    branch_not_equal_op = 5'h08,
    branch_carry_set_op = 5'h09,
    branch_carry_clear_op = 5'h0a,
    branch_same_higher_op = 5'h0b,
    branch_lower_op = 5'h0c,
    branch_signed_ge_op = 5'h0d,
    branch_signed_lt_op = 5'h0e,
    branch_halfcarry_set_op = 5'h0f,
    branch_halfcarry_clear_op = 5'h10,
    push_op = 5'h11,
    pop_op = 5'h12,
    sleep_op = 5'h13,
    watchdog_restart_op = 5'h14,
    break_op = 5'h15
  } bse_op_e;

  // ****************************************************************
  // Sequencer states.
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_BREAK = 2'b10
  } bse_state_e;

endpackage
